/* design/tsi_lane.sv */
`timescale 1ns/1ns
module tsi_lane (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic shift,
    input wire logic sample,
    input wire logic glob_en,
    input wire logic rx_in,
    input wire tsi_pkg::tsi_load_type load_val,
    output logic tx_bit,
    output logic tx_oe_n,
    output logic [7:0] rx_byte
);
    import tsi_pkg::*;

    logic [7:0] out_sh_r;
    logic drive_r;
    logic loop_r;

    // parallel to serial, msb first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_sh_r <= 8'h00;
            tx_bit <= 1'b1;
        end
        else if (load)
        begin
            tx_bit <= load_val.data[7];
            out_sh_r <= {load_val.data[6:0], 1'b0};
        end
        else if (shift)
        begin
            tx_bit <= out_sh_r[7];
            out_sh_r <= {out_sh_r[6:0], 1'b0};
        end
    end

    // per-channel controls held for the whole slot
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_r <= 1'b0;
            loop_r <= 1'b0;
        end
        else if (load)
        begin
            drive_r <= load_val.drive;
            loop_r <= load_val.loop;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_oe_n <= 1'b1;
        else
            tx_oe_n <= !(drive_r && glob_en);
    end

    // serial to parallel, loopback takes own tx bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_byte <= 8'h00;
        else if (sample)
            rx_byte <= {rx_byte[6:0], loop_r ? tx_bit : rx_in};
    end
endmodule // tsi_lane

/* design/tsi_pkg.sv */
package tsi_pkg;
    localparam int STREAMS = 8;
    localparam int CHANNELS = 32;
    localparam int DM_DEPTH = 256;
    // apb windows, paddr[11:10]
    localparam logic [1:0] WIN_REG = 2'h0;
    localparam logic [1:0] WIN_DM = 2'h1;
    localparam logic [1:0] WIN_CM = 2'h2;
    // memory select codes, same coding as windows
    localparam logic [1:0] MS_REG = 2'h0;
    localparam logic [1:0] MS_DM = 2'h1;
    localparam logic [1:0] MS_CM = 2'h2;
    // register indices
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h01;
    localparam logic [7:0] REG_STAT = 8'h02;
    // field positions
    localparam int CTRL_MS_LSB = 0;
    localparam int MODE_OSB_BIT = 0;
    localparam int CM_LOOP = 11;
    localparam int CM_CONST = 12;
    localparam int CM_PROC = 13;
    localparam int CM_DRIVE = 14;
    localparam int CM_CCO = 15;
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] CM_RST = 16'h0000;
    // phases within a 16-tick time slot
    localparam logic [3:0] PH_LOAD = 4'h0;
    localparam logic [3:0] PH_FETCH = 4'h8;
    // steady ticks before the idle sync level is trusted
    localparam logic [3:0] SYNC_RUN = 4'h8;

    typedef struct packed {
        logic [7:0] data;
        logic drive;
        logic loop;
    } tsi_load_type;

    typedef enum logic [1:0] {MP_IDLE, MP_WAIT, MP_HOLD, MP_PARK} tsi_mp_state_type;
endpackage

/* design/tsi_switch.sv */
// Contract
// - bus style pin high selects multiplexed port, low non-multiplexed.
// - low lines carry data 0-7 and mux address; upper lines data 8-15.
// - acknowledge low on completion, driven high at cycle end, then released.
// - control output: 256 bits per frame from per-channel control bits.
// - drive pin low and standby bit low tri-state all serial outputs.
// - 2.048 Mb/s streams, 32 channels per frame, same rate both ways.
// - frame sync polarity detected automatically, format chosen to match.
// - received channels become bytes written sequentially in 256-byte data memory.
// - channel and frame boundaries come from the 8 kHz frame pulse.
// - connection mode outputs data memory byte addressed by connection entry.
// - output byte fetched one time slot before it is sent.
// - one entry per output channel; many outputs may share one source.
// - processor mode repeats the written byte every frame until changed.
// - entry holds mode, delay, drive, loopback and control output bits.
// - channel marked undriven stays tri-stated for its whole slot.
// - global disable tri-states every channel whatever the entries say.
// - target picked by address plus memory select bit of control register.
// - any of 256 inputs to any of 256 outputs, non-blocking.
// - strobe variants of each host bus style decoded without glue; code decodes one variant only for non-multiplexed.
// - reset clears counters and registers, tri-states serial and data outputs.
// - mux mode: strobe/read level at latch strobe rise picks timing variant.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module tsi_switch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_master_clk,
    input wire logic frame_sync_input_n,
    input wire logic [tsi_pkg::STREAMS-1:0] serial_in_streams,
    output logic [tsi_pkg::STREAMS-1:0] serial_out_streams,
    output logic [tsi_pkg::STREAMS-1:0] serial_out_oe_n,
    output logic serial_control_bit_output,
    input wire logic output_drive_enable_pin,
    input wire logic host_bus_style_select,
    input wire logic address_latch_strobe,
    input wire logic data_strobe_or_read,
    input wire logic read_write_or_write,
    input wire logic chip_select_n,
    input wire logic [7:0] addr_lines,
    input wire logic [7:0] low_addr_data_lines_in,
    output logic [7:0] low_addr_data_lines_out,
    output logic low_addr_data_lines_oe_n,
    input wire logic [7:0] upper_data_lines_in,
    output logic [7:0] upper_data_lines_out,
    output logic upper_data_lines_oe_n,
    output logic transfer_acknowledge_n,
    output logic transfer_acknowledge_oe_n
);
    import tsi_pkg::*;

    logic [7:0] dm_r [DM_DEPTH];
    logic [15:0] cm_r [DM_DEPTH];
    logic [15:0] ctrl_r;
    logic [15:0] mode_r;
    tsi_load_type hold_r [STREAMS];
    logic [7:0] rx_byte [STREAMS];

    logic mclk_q_r;
    logic tick;
    logic [8:0] mcnt_r;
    logic [4:0] ch;
    logic [3:0] ph;
    logic [4:0] ch_nxt;
    logic [4:0] ch_prv;
    logic load_t;
    logic fetch_t;
    logic shift_t;
    logic sample_t;
    logic glob_en;
    logic slot_ok;

    logic last_fs_r;
    logic idle_r;
    logic locked_r;
    logic [3:0] run_r;
    logic pulse_start;

    // master clock edge and slot position
    assign tick = serial_master_clk && !mclk_q_r;
    assign ch = mcnt_r[8:4];
    assign ph = mcnt_r[3:0];
    assign ch_nxt = ch + 5'h01;
    assign ch_prv = ch - 5'h01;
    assign load_t = tick && (ph == PH_LOAD);
    assign fetch_t = tick && (ph == PH_FETCH);
    assign shift_t = tick && !mcnt_r[0] && (ph != PH_LOAD);
    assign sample_t = tick && mcnt_r[0];
    assign glob_en = output_drive_enable_pin || mode_r[MODE_OSB_BIT];
    assign slot_ok = !(load_t || fetch_t);
    assign pulse_start = locked_r && tick && (frame_sync_input_n != idle_r) && (last_fs_r == idle_r);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mclk_q_r <= 1'b0;
        else
            mclk_q_r <= serial_master_clk;
    end

    // idle level learnt from long steady runs; idle high means active-low pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_fs_r <= 1'b1;
            idle_r <= 1'b1;
            locked_r <= 1'b0;
            run_r <= 4'h0;
        end
        else if (tick)
        begin
            last_fs_r <= frame_sync_input_n;
            if (frame_sync_input_n != last_fs_r)
                run_r <= 4'h0;
            else if (run_r != SYNC_RUN)
                run_r <= run_r + 4'h1;
            if (run_r == SYNC_RUN)
            begin
                idle_r <= last_fs_r;
                locked_r <= 1'b1;
            end
        end
    end

    // 512 master ticks per frame: 32 slots of 8 bits, 2 ticks per bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mcnt_r <= 9'h000;
        else if (pulse_start)
            mcnt_r <= 9'h000;
        else if (tick)
            mcnt_r <= mcnt_r + 9'h001;
    end

    genvar gs;
    generate
        for (gs = 0; gs < STREAMS; gs++)
        begin : g_lane
            tsi_lane u_lane (
                .pclk(pclk),
                .presetn(presetn),
                .load(load_t),
                .shift(shift_t),
                .sample(sample_t),
                .glob_en(glob_en),
                .rx_in(serial_in_streams[gs]),
                .load_val(hold_r[gs]),
                .tx_bit(serial_out_streams[gs]),
                .tx_oe_n(serial_out_oe_n[gs]),
                .rx_byte(rx_byte[gs])
            );
        end
    endgenerate

    // completed channel of every stream stored at {stream, channel}
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < DM_DEPTH; i++)
                dm_r[i] <= 8'h00;
        end
        else if (load_t)
        begin
            for (int s = 0; s < STREAMS; s++)
                dm_r[{3'(s), ch_prv}] <= rx_byte[s];
        end
    end

    // fetch for next slot; latched copy keeps a loaded byte safe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int s = 0; s < STREAMS; s++)
                hold_r[s] <= '0;
        end
        else if (fetch_t)
        begin
            for (int s = 0; s < STREAMS; s++)
            begin
                if (cm_r[{3'(s), ch_nxt}][CM_PROC])
                    hold_r[s].data <= cm_r[{3'(s), ch_nxt}][7:0];
                else
                    hold_r[s].data <= dm_r[cm_r[{3'(s), ch_nxt}][7:0]];
                hold_r[s].drive <= cm_r[{3'(s), ch_nxt}][CM_DRIVE];
                hold_r[s].loop <= cm_r[{3'(s), ch_nxt}][CM_LOOP];
            end
        end
    end

    // control output: 8 bits per slot, each stream's bit held one bit time (two ticks)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serial_control_bit_output <= 1'b0;
        else if (tick)
            serial_control_bit_output <= cm_r[{mcnt_r[3:1], ch}][CM_CCO];
    end

    // microport front end
    tsi_mp_state_type mp_st_r;
    logic ale_q_r;
    logic mode1_r;
    logic [7:0] lat_addr_r;
    logic mp_acc;
    logic mp_rd;
    logic [7:0] mp_addr;
    logic [1:0] mp_tgt_r;
    logic [7:0] mp_idx_r;
    logic mp_wr_r;
    logic [15:0] mp_wd_r;
    logic mp_go;
    logic ap_go;

    always_comb
    begin
        if (!host_bus_style_select)
        begin
            mp_acc = !chip_select_n && !data_strobe_or_read;
            mp_rd = read_write_or_write;
            mp_addr = addr_lines;
        end
        else if (mode1_r)
        begin
            mp_acc = !chip_select_n && (!data_strobe_or_read || !read_write_or_write);
            mp_rd = !data_strobe_or_read;
            mp_addr = lat_addr_r;
        end
        else
        begin
            mp_acc = !chip_select_n && data_strobe_or_read;
            mp_rd = read_write_or_write;
            mp_addr = lat_addr_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ale_q_r <= 1'b0;
            mode1_r <= 1'b0;
            lat_addr_r <= 8'h00;
        end
        else
        begin
            ale_q_r <= address_latch_strobe;
            if (host_bus_style_select && address_latch_strobe)
                lat_addr_r <= low_addr_data_lines_in;
            if (host_bus_style_select && address_latch_strobe && !ale_q_r)
                mode1_r <= !data_strobe_or_read;
        end
    end

    // shared access path
    logic acc_go;
    logic acc_wr;
    logic [1:0] acc_tgt;
    logic [7:0] acc_idx;
    logic [15:0] acc_wd;
    logic [15:0] acc_rd;
    logic acc_bad;

    assign mp_go = (mp_st_r == MP_WAIT) && slot_ok;
    assign ap_go = psel && penable && !pready && slot_ok && !mp_go;
    assign acc_go = mp_go || ap_go;

    always_comb
    begin
        if (mp_go)
        begin
            acc_wr = mp_wr_r;
            acc_tgt = mp_tgt_r;
            acc_idx = mp_idx_r;
            acc_wd = mp_wd_r;
        end
        else
        begin
            acc_wr = pwrite;
            acc_tgt = paddr[11:10];
            acc_idx = paddr[9:2];
            acc_wd = pwdata[15:0];
        end
        acc_rd = 16'h0000;
        acc_bad = 1'b0;
        unique case (acc_tgt)
            WIN_REG:
            begin
                if (acc_idx == REG_CTRL)
                    acc_rd = ctrl_r;
                else if (acc_idx == REG_MODE)
                    acc_rd = mode_r;
                else if (acc_idx == REG_STAT)
                    acc_rd = {14'h0000, locked_r, idle_r};
                else
                    acc_bad = 1'b1;
                acc_bad = acc_bad || (acc_wr && acc_idx == REG_STAT);
            end
            WIN_DM:
            begin
                acc_rd = {8'h00, dm_r[acc_idx]};
                acc_bad = acc_wr;
            end
            WIN_CM:
                acc_rd = cm_r[acc_idx];
            default:
                acc_bad = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= CTRL_RST;
            mode_r <= MODE_RST;
        end
        else if (acc_go && acc_wr && !acc_bad && acc_tgt == WIN_REG)
        begin
            if (acc_idx == REG_CTRL)
                ctrl_r <= acc_wd;
            else
                mode_r <= acc_wd;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < DM_DEPTH; i++)
                cm_r[i] <= CM_RST;
        end
        else if (acc_go && acc_wr && acc_tgt == WIN_CM)
            cm_r[acc_idx] <= acc_wd;
    end

    // apb answer one cycle after the access is granted
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= ap_go;
            pslverr <= ap_go && acc_bad;
            if (ap_go)
                prdata <= {16'h0000, acc_bad ? 16'h0000 : acc_rd};
        end
    end

    // microport sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mp_st_r <= MP_IDLE;
            mp_tgt_r <= MS_REG;
            mp_idx_r <= 8'h00;
            mp_wr_r <= 1'b0;
            mp_wd_r <= 16'h0000;
            low_addr_data_lines_out <= 8'h00;
            upper_data_lines_out <= 8'h00;
            low_addr_data_lines_oe_n <= 1'b1;
            upper_data_lines_oe_n <= 1'b1;
            transfer_acknowledge_n <= 1'b1;
            transfer_acknowledge_oe_n <= 1'b1;
        end
        else
        begin
            unique case (mp_st_r)
                MP_IDLE:
                begin
                    if (mp_acc)
                    begin
                        mp_tgt_r <= ctrl_r[CTRL_MS_LSB +: 2];
                        mp_idx_r <= mp_addr;
                        mp_wr_r <= !mp_rd;
                        mp_wd_r <= {upper_data_lines_in, low_addr_data_lines_in};
                        mp_st_r <= MP_WAIT;
                    end
                end
                MP_WAIT:
                begin
                    if (!mp_acc)
                        mp_st_r <= MP_IDLE;
                    else if (mp_go)
                    begin
                        low_addr_data_lines_out <= acc_bad ? 8'h00 : acc_rd[7:0];
                        upper_data_lines_out <= acc_bad ? 8'h00 : acc_rd[15:8];
                        low_addr_data_lines_oe_n <= mp_wr_r;
                        upper_data_lines_oe_n <= mp_wr_r;
                        transfer_acknowledge_n <= 1'b0;
                        transfer_acknowledge_oe_n <= 1'b0;
                        mp_st_r <= MP_HOLD;
                    end
                end
                MP_HOLD:
                begin
                    if (!mp_acc)
                    begin
                        transfer_acknowledge_n <= 1'b1;
                        low_addr_data_lines_oe_n <= 1'b1;
                        upper_data_lines_oe_n <= 1'b1;
                        mp_st_r <= MP_PARK;
                    end
                end
                MP_PARK:
                begin
                    transfer_acknowledge_oe_n <= 1'b1;
                    mp_st_r <= MP_IDLE;
                end
            endcase
        end
    end
endmodule // tsi_switch

/* tb/tsi_serial_partner.sv */
`timescale 1ns/1ns
module tsi_serial_partner (
    output logic serial_master_clk,
    output logic frame_sync_input_n,
    output logic [tsi_pkg::STREAMS-1:0] serial_in_streams,
    input wire logic [tsi_pkg::STREAMS-1:0] serial_out_streams,
    input wire logic [tsi_pkg::STREAMS-1:0] serial_out_oe_n,
    input wire logic serial_control_bit_output
);
    import tsi_pkg::*;
    logic [8:0] pcnt_r = 9'h1F0;
    logic [7:0] rx_b;
    logic [7:0] sh_r [STREAMS];
    logic [STREAMS-1:0] dr_r;
    logic [8:0] cap [DM_DEPTH];
    logic cco_cap [DM_DEPTH];
    initial
    begin
        serial_master_clk = 1'b0;
        forever #122 serial_master_clk = ~serial_master_clk;
    end
    always @(posedge serial_master_clk)
        pcnt_r <= pcnt_r + 9'h001;
    wire [8:0] dcnt = pcnt_r - 9'h001;
    assign frame_sync_input_n = pcnt_r != 9'h000;
    always_comb
    begin
        for (int s = 0; s < STREAMS; s++)
        begin
            rx_b = {3'(s), dcnt[8:4]};
            serial_in_streams[s] = rx_b[3'h7 - dcnt[3:1]];
        end
    end
    always @(negedge serial_master_clk)
    begin
        if (pcnt_r[0])
        begin
            cco_cap[{pcnt_r[3:1], pcnt_r[8:4]}] = serial_control_bit_output;
            for (int s = 0; s < STREAMS; s++)
            begin
                sh_r[s] = {sh_r[s][6:0], serial_out_streams[s]};
                dr_r[s] = (pcnt_r[3:1] == 3'h0 || dr_r[s]) && !serial_out_oe_n[s];
                if (pcnt_r[3:1] == 3'h7)
                    cap[{3'(s), pcnt_r[8:4]}] = {dr_r[s], sh_r[s]};
            end
        end
    end
endmodule // tsi_serial_partner

/* tb/tsi_switch_monitor.sv */
`timescale 1ns/1ns
module tsi_switch_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [tsi_pkg::STREAMS-1:0] serial_out_oe_n,
    input wire logic host_bus_style_select,
    input wire logic data_strobe_or_read,
    input wire logic chip_select_n,
    input wire logic low_addr_data_lines_oe_n,
    input wire logic upper_data_lines_oe_n,
    input wire logic transfer_acknowledge_n,
    input wire logic transfer_acknowledge_oe_n
);
    import tsi_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic apb_req;
    assign apb_req = psel && penable && !pready;
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_apb_answer_bound: assert property (apb_req |-> ##[0:6] pready)
        else $error("apb answer late");
    a_unmapped_error: assert property (apb_req && paddr[11:10] == 2'h3 |-> ##[0:6] (pready && pslverr))
        else $error("unmapped not refused");
    a_dm_write_error: assert property (apb_req && pwrite && paddr[11:10] == WIN_DM |-> ##[0:6] (pready && pslverr))
        else $error("dm write not refused");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_reset_outputs_hiz: assert property ($rose(presetn) |-> serial_out_oe_n == 8'hFF && transfer_acknowledge_oe_n
        && low_addr_data_lines_oe_n) else $error("outputs driven after reset");
    a_ack_high_release: assert property ($rose(transfer_acknowledge_oe_n) |-> $past(transfer_acknowledge_n))
        else $error("ack released without high cycle");
    a_ack_one_high: assert property ($rose(transfer_acknowledge_n) && !transfer_acknowledge_oe_n
        |=> transfer_acknowledge_oe_n) else $error("ack not released");
    a_ack_on_access: assert property (!host_bus_style_select && !chip_select_n && !data_strobe_or_read
        && transfer_acknowledge_oe_n |-> ##[1:5] !transfer_acknowledge_n) else $error("no ack");
    a_data_with_ack: assert property (!low_addr_data_lines_oe_n |-> !upper_data_lines_oe_n && !transfer_acknowledge_n)
        else $error("data driven outside ack");
    c_apb_error: cover property (pready && pslverr);
    c_micro_ack: cover property ($fell(transfer_acknowledge_n));
    c_micro_read: cover property (!low_addr_data_lines_oe_n);
endmodule // tsi_switch_monitor

bind tsi_switch tsi_switch_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .serial_out_oe_n(serial_out_oe_n),
    .host_bus_style_select(host_bus_style_select), .data_strobe_or_read(data_strobe_or_read),
    .chip_select_n(chip_select_n), .low_addr_data_lines_oe_n(low_addr_data_lines_oe_n),
    .upper_data_lines_oe_n(upper_data_lines_oe_n), .transfer_acknowledge_n(transfer_acknowledge_n),
    .transfer_acknowledge_oe_n(transfer_acknowledge_oe_n));

/* tb/tsi_switch_test.sv */
`timescale 1ns/1ns
module tsi_switch_test;
    import tsi_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic serial_master_clk, frame_sync_input_n, serial_control_bit_output, output_drive_enable_pin;
    logic [STREAMS-1:0] serial_in_streams, serial_out_streams, serial_out_oe_n;
    logic data_strobe_or_read, read_write_or_write, chip_select_n, transfer_acknowledge_n, transfer_acknowledge_oe_n;
    logic [7:0] addr_lines, low_addr_data_lines_in, low_addr_data_lines_out, upper_data_lines_in, upper_data_lines_out;
    logic low_addr_data_lines_oe_n, upper_data_lines_oe_n;
    logic [15:0] host_data;
    int errors, tests_run, cycles;
    logic host_bus_style_select = 1'b0, address_latch_strobe = 1'b0;
    assign low_addr_data_lines_in = low_addr_data_lines_oe_n ? host_data[7:0] : low_addr_data_lines_out;
    assign upper_data_lines_in = upper_data_lines_oe_n ? host_data[15:8] : upper_data_lines_out;
    tsi_switch dut (.*);
    tsi_serial_partner u_far (.*);
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 99000)
        begin
            errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] er,
        input logic ee);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        chk({30'h0, pready, pslverr}, {30'h0, 1'b1, ee});
        if (!w)
            chk(prdata, er);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic mp(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
        int n = 0;
        chip_select_n <= 1'b0;
        data_strobe_or_read <= 1'b0;
        read_write_or_write <= !w;
        addr_lines <= a;
        host_data <= w ? d : ~exp;
        @(posedge pclk);
        while (transfer_acknowledge_n !== 1'b0 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        chk({transfer_acknowledge_n, transfer_acknowledge_oe_n}, 2'b00);
        if (!w)
            chk({upper_data_lines_out, low_addr_data_lines_out}, exp);
        chip_select_n <= 1'b1;
        data_strobe_or_read <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({transfer_acknowledge_oe_n, low_addr_data_lines_oe_n}, 2'b11);
    endtask
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge serial_master_clk);
        @(posedge pclk);
    endtask
    task automatic t_reset();
        chk({24'h0, serial_out_oe_n}, 32'hFF);
        chk({transfer_acknowledge_oe_n, low_addr_data_lines_oe_n, upper_data_lines_oe_n}, 3'b111);
        acc(1'b0, 12'h000, 32'h0, CTRL_RST, 1'b0);
        acc(1'b0, 12'h004, 32'h0, MODE_RST, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_regs();
        acc(1'b1, 12'h000, 32'h2, 32'h0, 1'b0);
        acc(1'b0, 12'h000, 32'h0, 32'h2, 1'b0);
        acc(1'b1, 12'h000, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 12'h008, 32'h1, 32'h0, 1'b1);
        acc(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 12'hC00, 32'h0, 32'h0, 1'b1);
        acc(1'b1, 12'h400, 32'h1, 32'h0, 1'b1);
        $display("register test done");
    endtask
    task automatic t_micro();
        mp(1'b0, 8'h00, 16'h0, 16'h0000);
        acc(1'b1, 12'h000, 32'h2, 32'h0, 1'b0);
        mp(1'b1, 8'h40, 16'h6011, 16'h0);
        acc(1'b0, 12'h900, 32'h0, 32'h6011, 1'b0);
        mp(1'b0, 8'h40, 16'h0, 16'h6011);
        acc(1'b1, 12'h000, 32'h1, 32'h0, 1'b0);
        mp(1'b0, 8'h43, 16'h0, 16'h0043);
        address_latch_strobe <= 1'b1;
        data_strobe_or_read <= 1'b0;
        host_bus_style_select <= 1'b1;
        @(posedge pclk);
        address_latch_strobe <= 1'b0;
        mp(1'b0, 8'h00, 16'h0, 16'h00BC);
        acc(1'b1, 12'h000, 32'h3, 32'h0, 1'b0);
        mp(1'b0, 8'h40, 16'h0, 16'h0000);
        acc(1'b1, 12'h000, 32'h0, 32'h0, 1'b0);
        $display("microport test done");
    endtask
    task automatic t_switch();
        acc(1'b1, 12'h890, 32'h60A5, 32'h0, 1'b0);
        acc(1'b1, 12'h814, 32'h4043, 32'h0, 1'b0);
        acc(1'b1, 12'hBFC, 32'hC043, 32'h0, 1'b0);
        acc(1'b1, 12'h980, 32'h303C, 32'h0, 1'b0);
        acc(1'b0, 12'h980, 32'h0, 32'h303C, 1'b0);
        wait_ticks(800);
        chk(u_far.cap[36], 9'h1A5);
        chk(u_far.cap[5], 9'h143);
        chk(u_far.cap[255], 9'h143);
        chk(u_far.cap[96][8], 1'b0);
        chk(u_far.cco_cap[255], 1'b1);
        chk(u_far.cco_cap[36], 1'b0);
        acc(1'b0, 12'h50C, 32'h0, 32'h43, 1'b0);
        acc(1'b0, 12'h008, 32'h0, 32'h3, 1'b0);
        acc(1'b1, 12'h890, 32'h605A, 32'h0, 1'b0);
        wait_ticks(544);
        chk(u_far.cap[36], 9'h15A);
        $display("switch test done");
    endtask
    task automatic t_global();
        output_drive_enable_pin <= 1'b0;
        wait_ticks(32);
        chk({24'h0, serial_out_oe_n}, 32'hFF);
        wait_ticks(512);
        chk(u_far.cap[36][8], 1'b0);
        acc(1'b1, 12'h004, 32'h1, 32'h0, 1'b0);
        wait_ticks(544);
        chk(u_far.cap[36], 9'h15A);
        output_drive_enable_pin <= 1'b1;
        acc(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
        $display("global disable test done");
    endtask
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        output_drive_enable_pin = 1'b1;
        data_strobe_or_read = 1'b1;
        read_write_or_write = 1'b1;
        chip_select_n = 1'b1;
        addr_lines = 8'h00;
        host_data = 16'h0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_regs();
        t_switch();
        t_micro();
        t_global();
        complete_run();
    end
endmodule // tsi_switch_test
